//--- logic/uvlim_regs.svh
// constants for the undervoltage torque limiter
// assumes: included by bare name by both ends and the carrier
`ifndef UVLIM_REGS_SVH
`define UVLIM_REGS_SVH
`define UV_SEL_OFF 2'h0
`define UV_SEL_HOST 2'h1
`define UV_SEL_DRIVE 2'h2
`define TLIM_MIN 7'h0a
`define TLIM_MAX 7'h64
`define TLIM_DEF 7'h32
`define TLIM_FULL 7'h64
`define REL_MIN 10'h00a
`define REL_MAX 10'h3e8
`define REL_DEF 10'h064
`define HOLD_MIN 16'h0014
`define HOLD_MAX 16'hc350
`define HOLD_DEF 16'h0014
`define MS_NS 1000000
`define CLK_NS 4
`define CYC_PER_MS (`MS_NS / `CLK_NS)
// apb register offsets of the host controller
`define A_CTRL 8'h00
`define A_TLIM 8'h04
`define A_REL 8'h08
`define A_HOLD 8'h0c
`define A_STAT 8'h10
`endif

//--- logic/uvlim_pkg.sv
// types shared by both ends of the undervoltage link
// assumes: nothing
package uvlim_pkg;
  typedef logic [1:0] uvSel_t;
  typedef logic [6:0] pct_t;
endpackage

//--- logic/uvlim_if.sv
// link between the drive and the host motion controller
// assumes: one clock for both ends
`timescale 1ns/100ps
interface uvlim_if;
  // settings from host
  uvlim_pkg::uvSel_t undervoltage_function_select;
  uvlim_pkg::pct_t reduced_voltage_torque_limit;
  logic [9:0] torque_limit_release_time;
  logic [15:0] power_loss_hold_time;
  logic servoOnCmd;
  logic servo_off_command;
  logic hostTorqueLimit;
  // status from drive
  logic uvWarn;
  logic servoReady;
  uvlim_pkg::pct_t torqueLimit;
  modport drive (input undervoltage_function_select, reduced_voltage_torque_limit, torque_limit_release_time,
    power_loss_hold_time, servoOnCmd, servo_off_command, hostTorqueLimit,
    output uvWarn, servoReady, torqueLimit);
  modport host (output undervoltage_function_select, reduced_voltage_torque_limit, torque_limit_release_time,
    power_loss_hold_time, servoOnCmd, servo_off_command, hostTorqueLimit,
    input uvWarn, servoReady, torqueLimit);
endinterface

//--- logic/uvlim_drive.sv
// drive end: undervoltage warning, internal torque limit, power-loss hold
// assumes: dcLow and mainOn are synchronous to mclk
// Summary of operation
// - select field: off, host limits, drive limits
// - host limits torque during warning
// - drive mode applies reduced limit at warning
// - drive mode releases limit over release time
// - reduced limit 10 to 100 percent, default 50
// - release time 10 to 1000 ms, default 100
// - hold time 20 to 50000 ms, default 20
// - operator sets 1000 ms hold for sag ride-through
// - keep torque limited when power returns (drive mode only; in host mode the host limit drops as soon as warning clears)
// - vertical axis limit not below holding torque
// - host sends servo off for immediate removal
// - warn when DC bus falls below threshold
// - ride through short loss, else servo off
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "uvlim_regs.svh"
module uvlim_drive #(
  parameter int CYC_MS = `CYC_PER_MS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link
  uvlim_if.drive lnk,
  // power stage
  input wire logic dcLow,
  input wire logic mainOn,
  output logic motorPower,
  output logic currentLimit
);
  typedef enum logic [2:0] {
    LIM_IDLE = 3'b001,
    LIM_HOLD = 3'b010,
    LIM_RAMP = 3'b100
  } limState_t;

  function automatic uvlim_pkg::pct_t clampPct(input uvlim_pkg::pct_t v);
    if (v < `TLIM_MIN)
      return `TLIM_MIN;
    else if (v > `TLIM_MAX)
      return `TLIM_MAX;
    return v;
  endfunction

  limState_t state_reg;
  logic [17:0] msDiv_reg;
  logic msTick;
  logic [15:0] lossMs_reg;
  logic [9:0] rampMs_reg;
  logic [9:0] relTime;
  logic [15:0] holdTime;
  logic detectOn;
  logic servoOn_reg;
  uvlim_pkg::pct_t limBase;
  logic [16:0] rampProd;
  uvlim_pkg::pct_t rampLim;

  assign detectOn = lnk.undervoltage_function_select == `UV_SEL_HOST ||
                    lnk.undervoltage_function_select == `UV_SEL_DRIVE;
  assign limBase = clampPct(lnk.reduced_voltage_torque_limit);
  assign relTime = lnk.torque_limit_release_time < `REL_MIN ? `REL_MIN :
                   lnk.torque_limit_release_time > `REL_MAX ? `REL_MAX : lnk.torque_limit_release_time;
  assign holdTime = lnk.power_loss_hold_time < `HOLD_MIN ? `HOLD_MIN :
                    lnk.power_loss_hold_time > `HOLD_MAX ? `HOLD_MAX : lnk.power_loss_hold_time;
  assign msTick = msDiv_reg == 18'(CYC_MS - 1);

  always_ff @(posedge mclk) begin
    if (!rst_b || msTick)
      msDiv_reg <= '0;
    else
      msDiv_reg <= msDiv_reg + 18'h1;
  end

  // warning follows the bus level while detection is on
  always_ff @(posedge mclk) begin
    if (!rst_b)
      lnk.uvWarn <= 1'b0;
    else
      lnk.uvWarn <= detectOn && dcLow;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b)
      currentLimit <= 1'b0;
    else
      currentLimit <= detectOn && dcLow;
  end

  // power-loss timer counts whole milliseconds with main power off
  always_ff @(posedge mclk) begin
    if (!rst_b || mainOn)
      lossMs_reg <= '0;
    else if (msTick && lossMs_reg != 16'hffff)
      lossMs_reg <= lossMs_reg + 16'h1;
  end

  // servo off on long loss; back on when power returns if still commanded
  always_ff @(posedge mclk) begin
    if (!rst_b || lnk.servo_off_command)
      servoOn_reg <= 1'b0;
    else if (!mainOn && lossMs_reg >= holdTime)
      servoOn_reg <= 1'b0;
    else if (lnk.servoOnCmd && mainOn)
      servoOn_reg <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b)
      motorPower <= 1'b0;
    else
      motorPower <= servoOn_reg && (mainOn || lossMs_reg < holdTime);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b)
      lnk.servoReady <= 1'b0;
    else
      lnk.servoReady <= mainOn || lossMs_reg < holdTime;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b)
      state_reg <= LIM_IDLE;
    else begin
      case (state_reg)
        LIM_IDLE:
          if (lnk.uvWarn && lnk.undervoltage_function_select == `UV_SEL_DRIVE)
            state_reg <= LIM_HOLD;
        LIM_HOLD:
          if (!lnk.uvWarn)
            state_reg <= LIM_RAMP;
        LIM_RAMP:
          if (lnk.uvWarn)
            state_reg <= LIM_HOLD;
          else if (msTick && rampMs_reg + 10'h1 >= relTime)
            state_reg <= LIM_IDLE;
        default:
          state_reg <= LIM_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || state_reg != LIM_RAMP)
      rampMs_reg <= '0;
    else if (msTick)
      rampMs_reg <= rampMs_reg + 10'h1;
  end

  // linear interpolation; ends exactly at full torque at release time
  assign rampProd = 17'((`TLIM_FULL - limBase) * rampMs_reg);
  assign rampLim = 7'(limBase + 7'(rampProd / 17'(relTime)));

  // limit stays reduced through the return of power until ramp ends
  always_ff @(posedge mclk) begin
    if (!rst_b)
      lnk.torqueLimit <= `TLIM_FULL;
    else begin
      case (state_reg)
        LIM_HOLD: lnk.torqueLimit <= limBase;
        LIM_RAMP: lnk.torqueLimit <= rampLim;
        default: lnk.torqueLimit <= `TLIM_FULL;
      endcase
    end
  end
endmodule

//--- logic/uvlim_host.sv
// host end: APB registers for settings, host torque limit on warning
// assumes: APB master in the mclk domain
`timescale 1ns/100ps
`include "uvlim_regs.svh"
module uvlim_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // link
  uvlim_if.host lnk
);
  logic wrEn;
  logic [31:0] ctrl_reg;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = psel && penable && pwrite;

  // ctrl: [1:0] select, [8] servo on, [9] servo off
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_reg <= '0;
      lnk.reduced_voltage_torque_limit <= `TLIM_DEF;
      lnk.torque_limit_release_time <= `REL_DEF;
      lnk.power_loss_hold_time <= `HOLD_DEF;
    end else if (wrEn) begin
      case (paddr)
        `A_CTRL: ctrl_reg <= pwdata;
        `A_TLIM: lnk.reduced_voltage_torque_limit <= pwdata[6:0];
        `A_REL: lnk.torque_limit_release_time <= pwdata[9:0];
        `A_HOLD: lnk.power_loss_hold_time <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  assign lnk.undervoltage_function_select = ctrl_reg[1:0];
  assign lnk.servoOnCmd = ctrl_reg[8];
  assign lnk.servo_off_command = ctrl_reg[9];
  // host limit follows warning in host mode; drops as soon as warning clears
  assign lnk.hostTorqueLimit = lnk.uvWarn && ctrl_reg[1:0] == `UV_SEL_HOST;

  always_ff @(posedge mclk) begin
    if (!rst_b)
      prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `A_CTRL: prdata <= ctrl_reg;
        `A_TLIM: prdata <= {25'h0, lnk.reduced_voltage_torque_limit};
        `A_REL: prdata <= {22'h0, lnk.torque_limit_release_time};
        `A_HOLD: prdata <= {16'h0, lnk.power_loss_hold_time};
        `A_STAT: prdata <= {22'h0, lnk.torqueLimit, lnk.hostTorqueLimit, lnk.servoReady, lnk.uvWarn};
        default: prdata <= '0;
      endcase
    end
  end
endmodule

//--- tb/uvlim_monitor.sv
// checker on the link between host and drive ends
// assumes: instantiated beside the interface, one clock
`timescale 1ns/100ps
`include "uvlim_regs.svh"
module uvlim_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link
  input wire uvlim_pkg::uvSel_t undervoltage_function_select,
  input wire uvlim_pkg::pct_t reduced_voltage_torque_limit,
  input wire logic servoOnCmd,
  input wire logic hostTorqueLimit,
  input wire logic uvWarn,
  input wire logic servoReady,
  input wire uvlim_pkg::pct_t torqueLimit,
  // power stage
  input wire logic mainOn
);
  wire off = undervoltage_function_select == `UV_SEL_OFF;
  wire hst = undervoltage_function_select == `UV_SEL_HOST;
  wire drv = undervoltage_function_select == `UV_SEL_DRIVE;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence warnHeld;
    (drv && uvWarn)[*3];
  endsequence
  // reduced must differ from full, else release is invisible
  sequence warnGone;
    warnHeld ##1 (drv && !uvWarn && reduced_voltage_torque_limit != `TLIM_FULL);
  endsequence
  off_quiet_a: assert property ($past(off) && off |-> !uvWarn) else $error("warn while off");
  hold_reduced_a: assert property (warnHeld |-> torqueLimit == reduced_voltage_torque_limit)
    else $error("limit not reduced");
  rise_only_a: assert property (!uvWarn && !$past(uvWarn) |-> torqueLimit >= $past(torqueLimit))
    else $error("limit fell");
  slow_release_a: assert property (warnGone |-> ##1 torqueLimit < `TLIM_FULL) else $error("jump");
  limit_range_a: assert property (torqueLimit <= `TLIM_FULL && torqueLimit >= `TLIM_MIN)
    else $error("limit range");
  host_follow_a: assert property (hst |-> hostTorqueLimit == uvWarn) else $error("host lim");
  host_quiet_a: assert property (!hst |-> !hostTorqueLimit) else $error("host lim on");
  // ready only drops after main power has gone
  ready_cause_a: assert property ($fell(servoReady) |-> !$past(mainOn)) else $error("ready");
endmodule

//--- tb/undervoltage_torque_limiter_test.sv
// bench: host and drive joined by the link, apb driven here
// assumes: one ms shortened to ten clocks
`timescale 1ns/100ps
`include "uvlim_regs.svh"
module undervoltage_torque_limiter_test;
  localparam int MS = 10;
  logic mclk = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic dcLow = 0;
  logic mainOn = 1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, q;
  logic pready, pslverr, motorPower, currentLimit;
  int errors = 0;
  int samples_checked = 0;
  uvlim_if lnk();
  uvlim_host uvlim_host_i(.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .lnk(lnk.host));
  uvlim_drive #(.CYC_MS(MS)) uvlim_drive_i(.mclk(mclk), .rst_b(rst_b), .lnk(lnk.drive), .dcLow(dcLow),
    .mainOn(mainOn), .motorPower(motorPower), .currentLimit(currentLimit));
  uvlim_monitor uvlim_monitor_i(.mclk(mclk), .rst_b(rst_b),
    .undervoltage_function_select(lnk.undervoltage_function_select),
    .reduced_voltage_torque_limit(lnk.reduced_voltage_torque_limit), .servoOnCmd(lnk.servoOnCmd),
    .hostTorqueLimit(lnk.hostTorqueLimit), .uvWarn(lnk.uvWarn), .servoReady(lnk.servoReady),
    .torqueLimit(lnk.torqueLimit), .mainOn(mainOn));
  initial forever #2 mclk = ~mclk;
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // idle cycle after each transfer keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1) @(posedge mclk);
    q = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge mclk);
  endtask
  task automatic stat;
    wait_ms(1);
    apb(0, `A_STAT, 0);
  endtask
  initial begin
    #40000;
    errors++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    apb(0, `A_CTRL, 0);
    chk(q[1:0], `UV_SEL_OFF);
    apb(0, `A_TLIM, 0);
    chk(q, `TLIM_DEF);
    apb(0, `A_REL, 0);
    chk(q, `REL_DEF);
    apb(0, `A_HOLD, 0);
    chk(q, `HOLD_DEF);
    apb(0, 8'h20, 0);
    chk(q, 0);
    dcLow <= 1;
    stat();
    chk(q[0], 0);
    chk(currentLimit, 0);
    apb(1, `A_CTRL, 32'h101);
    stat();
    chk({q[9:3], q[2], q[0]}, {`TLIM_FULL, 2'h3});
    chk(currentLimit, 1);
    dcLow <= 0;
    stat();
    chk(q[2], 0);
    apb(1, `A_TLIM, 32'h1e);
    apb(1, `A_REL, `REL_MIN);
    apb(1, `A_CTRL, 32'h102);
    dcLow <= 1;
    stat();
    chk({q[9:3], q[2], q[0]}, {7'h1e, 2'h1});
    dcLow <= 0;
    wait_ms(4);
    stat();
    chk(q[9:3] > 7'h1e && q[9:3] < `TLIM_FULL, 1);
    wait_ms(5);
    stat();
    chk({q[9:3], q[1]}, {`TLIM_FULL, 1'h1});
    mainOn <= 0;
    wait_ms(10);
    #1;
    chk({lnk.servoReady, motorPower}, 2'h3);
    mainOn <= 1;
    wait_ms(1);
    mainOn <= 0;
    wait_ms(25);
    #1;
    chk({lnk.servoReady, motorPower}, 2'h0);
    @(posedge mclk);
    mainOn <= 1;
    stat();
    chk({q[1], motorPower}, 2'h3);
    apb(1, `A_CTRL, 32'h302);
    wait_ms(1);
    chk(motorPower, 0);
    final_report();
  end
endmodule
